/* File: hw/port_pins_defines.svh */
// Contract
// - High page pin written one is weakly pulled high and usable as input.
// - During external data access, high page pins carry address bits 15..14.
// - High page pins also carry address bits 23..22, time-shared with bits 15..14.
// - Board holds fetch-select high; only internal code fetch exists.
// - Program store strobe stays low while executing internal code.
// - At reset strobe pin is sampled; low selects download kernel, else user code.
// - Address latch strobe marks valid low byte and page byte for external latches.
// - Low port is open-drain; a pin written one floats as an input.
// - During external access, low port multiplexes address bits 7..0 with data.
// - As external bus, low port drives ones strongly instead of floating.
// - Analog port pin resets to analog mode; writing zero makes it digital.
// - Enabled timer two counter increments on each falling edge of its input.
`ifndef PORT_PINS_DEFINES_SVH
`define PORT_PINS_DEFINES_SVH
`define HIGH_PAGE_RESET    2'b11
`define LOW_BUS_RESET      8'hFF
`define ANALOG_PIN_RESET   1'b1
`define STRAP_SAMPLE_CYCLES 4'h4
`define TIMER_TWO_RESET    16'h0000
`endif

/* File: hw/port_pins_pkg.sv */
package port_pins_pkg;
	typedef enum logic [6:0] {
		XS_IDLE  = 7'b000_0001,
		XS_PAGE  = 7'b000_0010,
		XS_LOW   = 7'b000_0100,
		XS_LATCH = 7'b000_1000,
		XS_MID   = 7'b001_0000,
		XS_DATA  = 7'b010_0000,
		XS_DONE  = 7'b100_0000
	} xfer_state_t;
	typedef enum logic [1:0] {
		BOOT_SAMPLE = 2'b01,
		BOOT_RUN    = 2'b10
	} boot_state_t;
endpackage : port_pins_pkg

/* File: hw/ext_bus_if.sv */
`timescale 1ns/10ps
interface ext_bus_if;
	logic        req;
	logic        wr;
	logic [23:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        done;
	logic        active;
	logic        page_phase;
	logic        low_drive;
	logic        latch;
	modport core (output req, output wr, output addr, output wdata,
		input rdata, input done, input active, input page_phase, input low_drive, input latch);
	modport seq (input req, input wr, input addr, input wdata,
		output rdata, output done, output active, output page_phase, output low_drive, output latch);
endinterface : ext_bus_if

/* File: hw/ext_bus_seq.sv */
`timescale 1ns/10ps
`include "port_pins_defines.svh"
module ext_bus_seq (
	input  wire logic   clock_i,
	input  wire logic   rst_b_i,
	input  wire logic [7:0] low_bus_in_i,
	ext_bus_if.seq      bus
);
	port_pins_pkg::xfer_state_t state_r;
	port_pins_pkg::xfer_state_t state_nxt;
	logic [7:0] rdata_r;
	logic       done_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			port_pins_pkg::XS_IDLE:  if (bus.req) state_nxt = port_pins_pkg::XS_PAGE;
			port_pins_pkg::XS_PAGE:  state_nxt = port_pins_pkg::XS_LOW;
			port_pins_pkg::XS_LOW:   state_nxt = port_pins_pkg::XS_LATCH;
			port_pins_pkg::XS_LATCH: state_nxt = port_pins_pkg::XS_MID;
			port_pins_pkg::XS_MID:   state_nxt = port_pins_pkg::XS_DATA;
			port_pins_pkg::XS_DATA:  state_nxt = port_pins_pkg::XS_DONE;
			// Back-to-back request may be taken while done is shown
			port_pins_pkg::XS_DONE:  state_nxt = bus.req ? port_pins_pkg::XS_PAGE : port_pins_pkg::XS_IDLE;
			default:                 state_nxt = port_pins_pkg::XS_IDLE;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_r <= port_pins_pkg::XS_IDLE;
			rdata_r <= 8'h00;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			done_r  <= (state_r == port_pins_pkg::XS_DATA);
			if (state_r == port_pins_pkg::XS_DATA && !bus.wr)
				rdata_r <= low_bus_in_i;
		end
	end

	// Page byte first, latched with the low byte, then middle byte holds for data
	assign bus.active     = (state_r != port_pins_pkg::XS_IDLE) && (state_r != port_pins_pkg::XS_DONE);
	assign bus.page_phase = (state_r == port_pins_pkg::XS_PAGE) || (state_r == port_pins_pkg::XS_LOW)
	                        || (state_r == port_pins_pkg::XS_LATCH);
	assign bus.latch      = (state_r == port_pins_pkg::XS_LOW) || (state_r == port_pins_pkg::XS_LATCH);
	assign bus.low_drive  = (state_r == port_pins_pkg::XS_PAGE) || (state_r == port_pins_pkg::XS_LOW)
	                        || (state_r == port_pins_pkg::XS_LATCH)
	                        || (bus.wr && (state_r == port_pins_pkg::XS_MID || state_r == port_pins_pkg::XS_DATA));
	assign bus.rdata      = rdata_r;
	assign bus.done       = done_r;
endmodule : ext_bus_seq

/* File: hw/port_pins_external_data_bus.sv */
`timescale 1ns/10ps
`include "port_pins_defines.svh"
module port_pins_external_data_bus (
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	input  wire logic [1:0]  high_page_wr_i,
	input  wire logic        high_page_we_i,
	input  wire logic [1:0]  high_page_in_i,
	output logic [1:0]       high_page_out_o,
	output logic [1:0]       high_page_oe_b_o,
	output logic [1:0]       high_page_pullup_o,
	output logic [1:0]       high_page_rd_o,
	input  wire logic [7:0]  low_bus_wr_i,
	input  wire logic        low_bus_we_i,
	input  wire logic [7:0]  low_bus_in_i,
	output logic [7:0]       low_bus_out_o,
	output logic [7:0]       low_bus_oe_b_o,
	output logic [7:0]       low_bus_rd_o,
	input  wire logic        xmem_req_i,
	input  wire logic        xmem_wr_i,
	input  wire logic [23:0] xmem_addr_i,
	input  wire logic [7:0]  xmem_wdata_i,
	output logic [7:0]       xmem_rdata_o,
	output logic             xmem_done_o,
	output logic             xmem_busy_o,
	output logic [7:0]       addr_mid_o,
	output logic [7:0]       addr_top_o,
	output logic             address_latch_strobe_o,
	input  wire logic        internal_fetch_select_i,
	output logic             internal_fetch_ok_o,
	input  wire logic        program_store_strobe_in_i,
	output logic             program_store_strobe_o,
	output logic             program_store_strobe_oe_b_o,
	output logic             boot_kernel_o,
	output logic             boot_done_o,
	input  wire logic        analog_port_wr_i,
	input  wire logic        analog_port_we_i,
	input  wire logic        analog_port_pin_zero_i,
	output logic             analog_channel_zero_en_o,
	output logic             analog_port_rd_o,
	input  wire logic        timer_two_count_en_i,
	output logic [15:0]      timer_two_count_o
);
	ext_bus_if bus ();
	ext_bus_seq u_seq (
		.clock_i      (clock_i),
		.rst_b_i      (rst_b_i),
		.low_bus_in_i (low_bus_in_i),
		.bus          (bus)
	);

	assign bus.req   = xmem_req_i && !bus.active;
	assign bus.addr  = xmem_addr_i;
	assign bus.wdata = xmem_wdata_i;

	logic [1:0]  high_latch_r;
	logic [7:0]  low_latch_r;
	logic [23:0] addr_r;
	logic        wr_r;
	logic [7:0]  wdata_r;
	logic        analog_mode_r;
	logic        t2_prev_r;
	logic [15:0] t2_count_r;
	port_pins_pkg::boot_state_t boot_r;
	logic [3:0]  strap_cnt_r;
	logic        kernel_r;
	// Registered so the direction holds for the whole access
	assign bus.wr    = wr_r;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			high_latch_r <= `HIGH_PAGE_RESET;
			low_latch_r  <= `LOW_BUS_RESET;
			addr_r       <= 24'h00_0000;
			wr_r         <= 1'b0;
			wdata_r      <= 8'h00;
		end else begin
			if (high_page_we_i)
				high_latch_r <= high_page_wr_i;
			if (low_bus_we_i)
				low_latch_r <= low_bus_wr_i;
			if (bus.req) begin
				addr_r  <= xmem_addr_i;
				wr_r    <= xmem_wr_i;
				wdata_r <= xmem_wdata_i;
			end
		end
	end

	// High page pins: bus byte during access, else latch with weak pull-up on ones
	wire [1:0] page_sel_bits = bus.page_phase ? addr_r[23:22] : addr_r[15:14];
	wire [1:0] high_val      = bus.active ? page_sel_bits : high_latch_r;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_high
			// Outside an access, ones only pulled weakly so an external driver can win
			assign high_page_oe_b_o[gi]   = bus.active ? 1'b0 : high_val[gi];
			assign high_page_pullup_o[gi] = high_val[gi];
		end
	endgenerate
	assign high_page_out_o = high_val;
	assign high_page_rd_o  = high_page_in_i;
	assign addr_mid_o      = addr_r[15:8];
	assign addr_top_o      = addr_r[23:16];

	// Low port: open-drain as GPIO, strong push-pull as bus
	wire [7:0] low_bus_val = bus.page_phase ? addr_r[7:0] : wdata_r;
	assign low_bus_out_o   = bus.low_drive ? low_bus_val : 8'h00;
	assign low_bus_oe_b_o  = bus.low_drive ? 8'h00 : (bus.active ? 8'hFF : low_latch_r);
	assign low_bus_rd_o    = low_bus_in_i;

	assign address_latch_strobe_o = bus.latch;
	assign xmem_rdata_o    = bus.rdata;
	assign xmem_done_o     = bus.done;
	assign xmem_busy_o     = bus.active;

	// No external fetch path exists, so this only reports the strap level
	assign internal_fetch_ok_o = internal_fetch_select_i;

	// Strap released as input for a few cycles after reset, then driven low
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			boot_r      <= port_pins_pkg::BOOT_SAMPLE;
			strap_cnt_r <= 4'h0;
			kernel_r    <= 1'b0;
		end else if (boot_r == port_pins_pkg::BOOT_SAMPLE) begin
			strap_cnt_r <= strap_cnt_r + 4'h1;
			if (strap_cnt_r == `STRAP_SAMPLE_CYCLES) begin
				kernel_r <= !program_store_strobe_in_i;
				boot_r   <= port_pins_pkg::BOOT_RUN;
			end
		end
	end
	wire sampling = (boot_r == port_pins_pkg::BOOT_SAMPLE);
	assign program_store_strobe_oe_b_o = sampling;
	assign program_store_strobe_o      = 1'b0;
	assign boot_kernel_o               = kernel_r;
	assign boot_done_o                 = !sampling;

	// Analog port pin and timer two count input
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			analog_mode_r <= `ANALOG_PIN_RESET;
			t2_prev_r     <= 1'b0;
			t2_count_r    <= `TIMER_TWO_RESET;
		end else begin
			if (analog_port_we_i)
				analog_mode_r <= analog_port_wr_i;
			t2_prev_r <= analog_port_pin_zero_i;
			if (timer_two_count_en_i && t2_prev_r && !analog_port_pin_zero_i)
				t2_count_r <= t2_count_r + 16'h0001;
		end
	end
	assign analog_channel_zero_en_o = analog_mode_r;
	assign analog_port_rd_o         = analog_mode_r ? 1'b0 : analog_port_pin_zero_i;
	assign timer_two_count_o        = t2_count_r;
endmodule : port_pins_external_data_bus

/* File: verif/port_pins_sva.sv */
`timescale 1ns/10ps
module port_pins_sva (
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic        xmem_req_i,
	input wire logic [23:0] xmem_addr_i,
	input wire logic        xmem_busy_o,
	input wire logic        xmem_done_o,
	input wire logic [7:0]  addr_mid_o,
	input wire logic [7:0]  addr_top_o,
	input wire logic        address_latch_strobe_o,
	input wire logic [7:0]  low_bus_out_o,
	input wire logic [7:0]  low_bus_oe_b_o,
	input wire logic        internal_fetch_select_i,
	input wire logic        internal_fetch_ok_o,
	input wire logic        program_store_strobe_o,
	input wire logic        analog_channel_zero_en_o,
	input wire logic        analog_port_rd_o,
	input wire logic [15:0] timer_two_count_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	wire take = xmem_req_i && !xmem_busy_o;
	sequence s_addr;
		##1 xmem_busy_o && low_bus_oe_b_o == 8'h00 && low_bus_out_o == $past(xmem_addr_i[7:0]);
	endsequence
	sequence s_latch;
		##2 address_latch_strobe_o [*2];
	endsequence
	AST_LOW_ADDR: assert property (take |-> s_addr) else $error("low address byte wrong");
	AST_LATCH: assert property (take |-> s_latch) else $error("latch strobe wrong");
	AST_DONE: assert property (take |-> ##6 xmem_done_o && !xmem_busy_o) else $error("done late");
	AST_MID: assert property (take |=> addr_mid_o == $past(xmem_addr_i[15:8])) else $error("mid byte");
	AST_TOP: assert property (take |=> addr_top_o == $past(xmem_addr_i[23:16])) else $error("top byte");
	AST_OPEN: assert property (!xmem_busy_o && !xmem_done_o |-> (low_bus_out_o & ~low_bus_oe_b_o) == 8'h00)
		else $error("open drain drove one");
	AST_STROBE: assert property (program_store_strobe_o == 1'b0) else $error("store strobe high");
	AST_FETCH: assert property (internal_fetch_ok_o == internal_fetch_select_i) else $error("fetch ok");
	AST_ANALOG: assert property (analog_channel_zero_en_o |-> !analog_port_rd_o) else $error("analog rd");
	AST_COUNT: assert property ($changed(timer_two_count_o) |->
		timer_two_count_o == $past(timer_two_count_o) + 16'h0001) else $error("count step");
endmodule : port_pins_sva
bind port_pins_external_data_bus port_pins_sva chk_u (.clock_i, .rst_b_i, .xmem_req_i, .xmem_addr_i, .xmem_busy_o,
	.xmem_done_o, .addr_mid_o, .addr_top_o, .address_latch_strobe_o, .low_bus_out_o, .low_bus_oe_b_o,
	.internal_fetch_select_i, .internal_fetch_ok_o, .program_store_strobe_o, .analog_channel_zero_en_o,
	.analog_port_rd_o, .timer_two_count_o);

/* File: verif/xmem_model.sv */
`timescale 1ns/10ps
module xmem_model (
	input  wire logic       clock_i,
	input  wire logic       latch_i,
	input  wire logic       busy_i,
	input  wire logic [7:0] out_i,
	input  wire logic [7:0] oe_b_i,
	output logic      [7:0] level_o
);
	logic [7:0] mem [256];
	logic [7:0] addr_r;
	logic       data_r = 1'b0;
	logic [7:0] last_r = 8'h00;
	// Released bus never shows a stale value
	wire  [7:0] ext = data_r ? mem[addr_r] : ~last_r;
	assign level_o = (out_i & ~oe_b_i) | (ext & oe_b_i);
	always @(posedge clock_i) begin
		last_r <= level_o;
		if (latch_i) addr_r <= out_i;
		data_r <= busy_i && (data_r || $fell(latch_i));
		if (data_r && oe_b_i == 8'h00) mem[addr_r] <= out_i;
	end
endmodule : xmem_model

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic clock_i = 0, rst_b_i = 0, strap = 1, internal_fetch_select_i = 1;
	logic [1:0] high_page_wr_i = 2'h3, hp_ext = 2'h3;
	logic high_page_we_i = 0, low_bus_we_i = 0, xmem_req_i = 0, xmem_wr_i = 0, analog_port_wr_i = 1;
	logic analog_port_we_i = 0, analog_port_pin_zero_i = 1, timer_two_count_en_i = 0;
	logic [7:0] low_bus_wr_i = 8'hFF, xmem_wdata_i = 8'h00;
	logic [23:0] xmem_addr_i = 24'h00_0000;
	wire [1:0] high_page_out_o, high_page_oe_b_o, high_page_pullup_o, high_page_rd_o;
	wire [1:0] high_page_in_i = (high_page_out_o & ~high_page_oe_b_o) | (hp_ext & high_page_oe_b_o);
	wire [7:0] low_bus_in_i, low_bus_out_o, low_bus_oe_b_o, low_bus_rd_o, xmem_rdata_o, addr_mid_o, addr_top_o;
	wire xmem_done_o, xmem_busy_o, address_latch_strobe_o, internal_fetch_ok_o, program_store_strobe_o;
	wire program_store_strobe_oe_b_o, boot_kernel_o, boot_done_o, analog_channel_zero_en_o, analog_port_rd_o;
	wire program_store_strobe_in_i = program_store_strobe_oe_b_o ? strap : program_store_strobe_o;
	wire [15:0] timer_two_count_o;
	int mismatches = 0, compares = 0;
	logic [32:0] rows [6] = '{{1'b1, 24'hC0_8012, 8'hA5}, {1'b1, 24'h40_4034, 8'h5A}, {1'b1, 24'h00_C056, 8'hFF},
		{1'b0, 24'hC0_8012, 8'hA5}, {1'b0, 24'h40_4034, 8'h5A}, {1'b0, 24'h00_C056, 8'hFF}};
	port_pins_external_data_bus uut (.*);
	xmem_model mem_u (.clock_i, .latch_i(address_latch_strobe_o), .busy_i(xmem_busy_o), .out_i(low_bus_out_o),
		.oe_b_i(low_bus_oe_b_o), .level_o(low_bus_in_i));
	initial forever #5 clock_i = ~clock_i;
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc
	task automatic do_reset(input logic s);
		cyc(1);
		rst_b_i <= 0;
		strap <= s;
		cyc(6);
		rst_b_i <= 1;
		#1 chk("strap_oe", 1, program_store_strobe_oe_b_o);
		cyc(6);
		#1 chk("boot", {1'b1, ~s}, {boot_done_o, boot_kernel_o});
	endtask : do_reset
	task automatic xfer(input logic [32:0] r);
		int n;
		cyc(1);
		xmem_req_i <= 1;
		{xmem_wr_i, xmem_addr_i, xmem_wdata_i} <= r;
		cyc(1);
		xmem_req_i <= 0;
		#1 chk("top", r[31:30], high_page_out_o);
		cyc(3);
		#1 chk("mid", r[23:22], high_page_out_o);
		n = 0;
		while (xmem_done_o !== 1'b1 && n < 10) begin
			cyc(1);
			#1 n++;
		end
		chk("done", 2, n);
		if (!r[32]) chk("rdata", r[7:0], xmem_rdata_o);
	endtask : xfer
	initial begin
		do_reset(1'b0);
		chk("rst", {8'hFF, 2'h3, 1'b1, 1'b0}, {low_bus_oe_b_o, high_page_pullup_o, analog_channel_zero_en_o,
			xmem_busy_o});
		foreach (rows[i]) xfer(rows[i]);
		cyc(1);
		low_bus_wr_i <= 8'h0F;
		low_bus_we_i <= 1;
		high_page_wr_i <= 2'h1;
		high_page_we_i <= 1;
		hp_ext <= 2'h2;
		analog_port_wr_i <= 0;
		analog_port_we_i <= 1;
		timer_two_count_en_i <= 1;
		cyc(1);
		{low_bus_we_i, high_page_we_i, analog_port_we_i} <= 3'h0;
		repeat (3) begin
			cyc(2);
			analog_port_pin_zero_i <= 0;
			cyc(2);
			analog_port_pin_zero_i <= 1;
		end
		cyc(2);
		#1 chk("gpio", {8'h0F, 4'h0}, {low_bus_oe_b_o, low_bus_rd_o[7:4]});
		chk("high", {2'h1, 2'h0}, {high_page_pullup_o, high_page_rd_o});
		chk("analog", 2'h1, {analog_channel_zero_en_o, analog_port_rd_o});
		chk("count", 3, timer_two_count_o);
		do_reset(1'b1);
		print_verdict();
	end
	// Whole run is under a hundred cycles; this only cuts a hang
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
endmodule : tb_top
